// ===== src/lcr_ctrl.sv
// lid-closure detection and recalibration configuration block
`timescale 1ns/100ps
module lcr_ctrl (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // host register port
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  // measurement side
  input wire logic SAMPLE_DONE_IN,
  input wire logic [111:0] SENSOR_DELTA_IN,
  input wire logic [13:0] NEG_DELTA_IN,
  input wire logic [55:0] SENSOR_THRESH_IN,
  input wire logic [27:0] LID_TH_CODE_IN,
  input wire logic [13:0] NOISE_STATUS_IN,
  input wire logic [13:0] RECAL_EN_IN,
  // group status handshake
  input wire logic LID_EVENT_CLR_IN,
  output logic LID_EVENT_OUT,
  output logic ALERT_OUT,
  output logic [13:0] LID_STATUS_OUT,
  // noise routing
  output logic [13:0] NOISE_LID_OUT,
  output logic [13:0] NOISE_TOUCH_OUT,
  // threshold broadcast
  output logic [7:0] THR_LOAD_OUT,
  output logic [6:0] THR_DATA_OUT,
  // recalibration
  output logic [13:0] NEG_RECAL_OUT,
  output logic AVG_SAMPLE_OUT,
  output logic [3:0] AVG_SHIFT_OUT,
  output logic [13:0] BASE_UPDATE_OUT
);
  // configuration registers, evaluation strobe and update counter
  logic [7:0] lid_detect_config_q;
  logic [7:0] lid_debounce_count_q;
  logic [7:0] lid_mask_buttons_q;
  logic [7:0] lid_mask_grouped_q;
  logic [7:0] recalibration_setup_q;
  logic eval_q;
  logic [12:0] upd_cnt_q;

  // popcount of a seven-bit mask
  function automatic logic [2:0] pop7(input logic [6:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 7; i++) begin
      n = n + {2'h0, v[i]};
    end
    return n;
  endfunction : pop7

  // field decode
  // reserved bits are never stored, so they cannot disturb a decode
  wire lid_enable = lid_detect_config_q[lcr_pkg::LID_ENABLE_BIT];
  wire exact_match_select = lid_detect_config_q[lcr_pkg::EXACT_MATCH_BIT];
  wire cover_alert_enable = lid_detect_config_q[lcr_pkg::ALERT_EN_BIT];
  wire button_threshold_broadcast =
    recalibration_setup_q[lcr_pkg::BTN_BCAST_BIT];
  wire group_threshold_broadcast =
    recalibration_setup_q[lcr_pkg::GRP_BCAST_BIT];
  wire [1:0] negative_run_length =
    recalibration_setup_q[lcr_pkg::NEG_RUN_LSB +: 2];
  wire [2:0] cal_cfg = recalibration_setup_q[lcr_pkg::CAL_CFG_LSB +: 3];
  wire [6:0] button_cover_mask = lid_mask_buttons_q[6:0];
  wire [6:0] group_cover_mask = lid_mask_grouped_q[6:0];
  wire button_one_cover_mask = button_cover_mask[0];
  wire group_last_cover_mask = group_cover_mask[6];

  // register write decode
  wire wr_cfg = REG_WR_IN && (REG_ADDR_IN == lcr_pkg::ADDR_LID_CFG);
  wire wr_queue = REG_WR_IN && (REG_ADDR_IN == lcr_pkg::ADDR_LID_QUEUE);
  wire wr_mbtn = REG_WR_IN && (REG_ADDR_IN == lcr_pkg::ADDR_MASK_BTN);
  wire wr_mgrp = REG_WR_IN && (REG_ADDR_IN == lcr_pkg::ADDR_MASK_GRP);
  wire wr_recal = REG_WR_IN && (REG_ADDR_IN == lcr_pkg::ADDR_RECAL);
  wire wr_thr = REG_WR_IN && (REG_ADDR_IN >= lcr_pkg::ADDR_THR_FIRST)
                && (REG_ADDR_IN <= lcr_pkg::ADDR_THR_GROUP);
  wire [2:0] thr_idx = 3'(REG_ADDR_IN - lcr_pkg::ADDR_THR_FIRST);

  // broadcast fan-out: writes to the first threshold can fan out,
  // the others always land on their own register only
  // the data bus is shared, so every strobed register takes one value
  logic [7:0] thr_load_d;
  always_comb begin
    thr_load_d = 8'h00;
    if (wr_thr) begin
      thr_load_d[thr_idx] = 1'b1;
      if (thr_idx == 3'h0) begin
        if (button_threshold_broadcast) begin
          thr_load_d[6:1] = 6'h3f;
        end
        if (group_threshold_broadcast) begin
          thr_load_d[7] = 1'b1;
        end
      end
    end
  end

  // read mux, unmapped addresses read zero
  // the answer is registered, so it lags the address by one cycle
  logic [7:0] rdata_d;
  always_comb begin
    unique case (REG_ADDR_IN)
      lcr_pkg::ADDR_LID_CFG: rdata_d = lid_detect_config_q;
      lcr_pkg::ADDR_LID_QUEUE: rdata_d = lid_debounce_count_q;
      lcr_pkg::ADDR_MASK_BTN: rdata_d = lid_mask_buttons_q;
      lcr_pkg::ADDR_MASK_GRP: rdata_d = lid_mask_grouped_q;
      lcr_pkg::ADDR_RECAL: rdata_d = recalibration_setup_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // register storage; reserved bits are masked on write
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      lid_detect_config_q <= lcr_pkg::RST_LID_CFG;
      lid_debounce_count_q <= lcr_pkg::RST_LID_QUEUE;
      lid_mask_buttons_q <= lcr_pkg::RST_MASK;
      lid_mask_grouped_q <= lcr_pkg::RST_MASK;
      recalibration_setup_q <= lcr_pkg::RST_RECAL;
    end else begin
      // an unmapped write matches no decode and is simply dropped
      if (wr_cfg) begin
        lid_detect_config_q <= REG_WDATA_IN & lcr_pkg::WMASK_LID_CFG;
      end
      if (wr_queue) begin
        lid_debounce_count_q <= REG_WDATA_IN & lcr_pkg::WMASK_QUEUE;
      end
      if (wr_mbtn) begin
        lid_mask_buttons_q <= REG_WDATA_IN & lcr_pkg::WMASK_MASK;
      end
      if (wr_mgrp) begin
        lid_mask_grouped_q <= REG_WDATA_IN & lcr_pkg::WMASK_MASK;
      end
      if (wr_recal) begin
        recalibration_setup_q <= REG_WDATA_IN & lcr_pkg::WMASK_RECAL;
      end
    end
  end

  // read data and threshold broadcast strobes
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      REG_RDATA_OUT <= 8'h00;
      THR_LOAD_OUT <= 8'h00;
      THR_DATA_OUT <= 7'h00;
    end else begin
      REG_RDATA_OUT <= rdata_d;
      THR_LOAD_OUT <= thr_load_d;
      THR_DATA_OUT <= REG_WDATA_IN[6:0];
    end
  end

  // queue length: zero decodes as one, seven gives the eight maximum
  // a 3-bit field cannot say eight directly, so its top code stands in
  wire [2:0] queue_field = lid_debounce_count_q[2:0];
  wire [3:0] queue_len = (queue_field == 3'h0) ? 4'h1 :
                         (queue_field == 3'h7) ? 4'h8 :
                         {1'b0, queue_field};

  // negative run limit decode
  // the off code maps to a zero limit, which each channel treats as off
  logic [5:0] neg_limit;
  always_comb begin
    unique case (negative_run_length)
      2'b00: neg_limit = lcr_pkg::NEG_RUN_8;
      2'b01: neg_limit = lcr_pkg::NEG_RUN_16;
      2'b10: neg_limit = lcr_pkg::NEG_RUN_32;
      2'b11: neg_limit = lcr_pkg::NEG_RUN_OFF;
    endcase
  end

  // recal samples, update interval and averaging shift, one table
  // shared by every sensor
  // the longest settings only stretch the interval, not the average
  logic [8:0] avg_len;
  logic [12:0] upd_len;
  logic [3:0] avg_shift;
  always_comb begin
    avg_len = lcr_pkg::AVG_256;
    avg_shift = lcr_pkg::SHIFT_256;
    unique case (cal_cfg)
      3'h0: begin
        avg_len = lcr_pkg::AVG_16;
        avg_shift = lcr_pkg::SHIFT_16;
        upd_len = lcr_pkg::UPD_16;
      end
      3'h1: begin
        avg_len = lcr_pkg::AVG_32;
        avg_shift = lcr_pkg::SHIFT_32;
        upd_len = lcr_pkg::UPD_32;
      end
      3'h2: begin
        avg_len = lcr_pkg::AVG_64;
        avg_shift = lcr_pkg::SHIFT_64;
        upd_len = lcr_pkg::UPD_64;
      end
      3'h3: upd_len = lcr_pkg::UPD_256;
      3'h4: upd_len = lcr_pkg::UPD_1024;
      3'h5: upd_len = lcr_pkg::UPD_2048;
      3'h6: upd_len = lcr_pkg::UPD_4096;
      3'h7: upd_len = lcr_pkg::UPD_7936;
    endcase
  end

  // lid threshold per sensor: sensors 8-14 share the group threshold
  // codes 0..3 shift right by 4..1, one sixteenth up to one half; a
  // plain shift needs no divider but truncates small thresholds
  logic [13:0] above;
  genvar g;
  generate
    for (g = 0; g < lcr_pkg::NUM_SENS; g++) begin : g_sens
      localparam int TI = (g < lcr_pkg::NUM_BTN) ? g : lcr_pkg::NUM_BTN;
      wire [6:0] thr = SENSOR_THRESH_IN[TI*7 +: 7];
      wire [1:0] code = LID_TH_CODE_IN[g*2 +: 2];
      wire [2:0] shamt = lcr_pkg::LID_SHIFT_BASE - {1'b0, code};
      wire [6:0] lid_th = thr >> shamt;
      wire [7:0] delta = SENSOR_DELTA_IN[g*8 +: 8];
      assign above[g] = delta > {1'b0, lid_th};

      lcr_chan u_chan (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .sample_in(SAMPLE_DONE_IN),
        .above_in(above[g]),
        .queue_len_in(queue_len),
        .neg_in(NEG_DELTA_IN[g]),
        .neg_limit_in(neg_limit),
        .status_out(LID_STATUS_OUT[g]),
        .neg_trig_out(NEG_RECAL_OUT[g])
      );
    end
  endgenerate

  // pattern evaluation on settled status bits; in count mode a pattern
  // with no bits set meets its own term at once, so software clears
  // both patterns to switch detection off
  wire [6:0] stat_btn = LID_STATUS_OUT[6:0];
  wire [6:0] stat_grp = LID_STATUS_OUT[13:7];
  wire [2:0] n_stat_btn = pop7(stat_btn);
  wire [2:0] n_stat_grp = pop7(stat_grp);
  wire [2:0] n_mask_btn = pop7(button_cover_mask);
  wire [2:0] n_mask_grp = pop7(group_cover_mask);
  wire [3:0] n_stat_all = {1'b0, n_stat_btn} + {1'b0, n_stat_grp};
  wire [3:0] n_mask_all = {1'b0, n_mask_btn} + {1'b0, n_mask_grp};
  wire masks_zero = (button_cover_mask == 7'h00) &&
                    (group_cover_mask == 7'h00);
  wire exact_hit = ((stat_btn & button_cover_mask) == button_cover_mask) &&
                   ((stat_grp & group_cover_mask) == group_cover_mask);
  wire count_hit = (n_stat_btn >= n_mask_btn) ||
                   (n_stat_grp >= n_mask_grp) ||
                   (n_stat_all >= n_mask_all);
  wire lid_hit = lid_enable && !masks_zero &&
                 (exact_match_select ? exact_hit : count_hit);
  wire event_set = eval_q && lid_hit;

  // evaluation strobe one cycle after each sample, so the pattern sees
  // the status bits that this sample has just settled
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      eval_q <= 1'b0;
    end else begin
      eval_q <= SAMPLE_DONE_IN;
    end
  end

  // event flag: a new detection wins over a clear in the same cycle;
  // all-zero patterns force it clear regardless
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      LID_EVENT_OUT <= 1'b0;
      ALERT_OUT <= 1'b0;
    end else begin
      if (masks_zero) begin
        LID_EVENT_OUT <= 1'b0;
      end else if (event_set) begin
        LID_EVENT_OUT <= 1'b1;
      end else if (LID_EVENT_CLR_IN) begin
        LID_EVENT_OUT <= 1'b0;
      end
      ALERT_OUT <= event_set && cover_alert_enable;
    end
  end

  // noise indications follow lid detection while it is enabled
  // both copies are registered so they swap on the same edge
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      NOISE_LID_OUT <= 14'h0000;
      NOISE_TOUCH_OUT <= 14'h0000;
    end else begin
      NOISE_LID_OUT <= lid_enable ? NOISE_STATUS_IN : 14'h0000;
      NOISE_TOUCH_OUT <= lid_enable ? 14'h0000 : NOISE_STATUS_IN;
    end
  end

  // update interval in polling cycles; averaging covers the last
  // avg_len cycles so the average is fresh at the update. A count left
  // past the end by a shorter setting wraps at once.
  // the update strobe copies the enables, so only enabled sensors rebase
  wire upd_last = upd_cnt_q >= upd_len - 13'h0001;
  wire avg_window = upd_cnt_q >= upd_len - {4'h0, avg_len};
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      upd_cnt_q <= 13'h0000;
      AVG_SAMPLE_OUT <= 1'b0;
      AVG_SHIFT_OUT <= lcr_pkg::SHIFT_256;
      BASE_UPDATE_OUT <= 14'h0000;
    end else begin
      AVG_SHIFT_OUT <= avg_shift;
      AVG_SAMPLE_OUT <= SAMPLE_DONE_IN && avg_window;
      BASE_UPDATE_OUT <= (SAMPLE_DONE_IN && upd_last) ?
                         RECAL_EN_IN : 14'h0000;
      if (SAMPLE_DONE_IN) begin
        upd_cnt_q <= upd_last ? 13'h0000 : upd_cnt_q + 13'h0001;
      end
    end
  end

  // mask bits kept as named fields for the end sensors of each pattern
  wire unused_ok = button_one_cover_mask ^ group_last_cover_mask;
endmodule : lcr_ctrl

// ===== src/lcr_pkg.sv
// constants for lid-closure detection and recalibration control
package lcr_pkg;
  // register addresses
  localparam logic [7:0] ADDR_LID_CFG = 8'h2b;
  localparam logic [7:0] ADDR_LID_QUEUE = 8'h2c;
  localparam logic [7:0] ADDR_MASK_BTN = 8'h2d;
  localparam logic [7:0] ADDR_MASK_GRP = 8'h2e;
  localparam logic [7:0] ADDR_RECAL = 8'h2f;
  localparam logic [7:0] ADDR_THR_FIRST = 8'h30;
  localparam logic [7:0] ADDR_THR_GROUP = 8'h37;
  // reset values
  localparam logic [7:0] RST_LID_CFG = 8'h00;
  localparam logic [7:0] RST_LID_QUEUE = 8'h02;
  localparam logic [7:0] RST_MASK = 8'h7f;
  localparam logic [7:0] RST_RECAL = 8'h93;
  // field positions
  localparam int LID_ENABLE_BIT = 7;
  localparam int EXACT_MATCH_BIT = 1;
  localparam int ALERT_EN_BIT = 0;
  localparam int BTN_BCAST_BIT = 7;
  localparam int GRP_BCAST_BIT = 6;
  localparam int NEG_RUN_LSB = 3;
  localparam int CAL_CFG_LSB = 0;
  // writable-bit masks, reserved bits read zero
  localparam logic [7:0] WMASK_LID_CFG = 8'h83;
  localparam logic [7:0] WMASK_QUEUE = 8'h07;
  localparam logic [7:0] WMASK_MASK = 8'h7f;
  localparam logic [7:0] WMASK_RECAL = 8'hdf;
  // sizes
  localparam int NUM_BTN = 7;
  localparam int NUM_SENS = 14;
  localparam int NUM_THR = 8;
  // negative delta run lengths
  localparam logic [5:0] NEG_RUN_8 = 6'h08;
  localparam logic [5:0] NEG_RUN_16 = 6'h10;
  localparam logic [5:0] NEG_RUN_32 = 6'h20;
  localparam logic [5:0] NEG_RUN_OFF = 6'h00;
  // recalibration samples and update interval (polling cycles)
  localparam logic [8:0] AVG_16 = 9'h010;
  localparam logic [8:0] AVG_32 = 9'h020;
  localparam logic [8:0] AVG_64 = 9'h040;
  localparam logic [8:0] AVG_256 = 9'h100;
  localparam logic [12:0] UPD_16 = 13'h0010;
  localparam logic [12:0] UPD_32 = 13'h0020;
  localparam logic [12:0] UPD_64 = 13'h0040;
  localparam logic [12:0] UPD_256 = 13'h0100;
  localparam logic [12:0] UPD_1024 = 13'h0400;
  localparam logic [12:0] UPD_2048 = 13'h0800;
  localparam logic [12:0] UPD_4096 = 13'h1000;
  localparam logic [12:0] UPD_7936 = 13'h1f00;
  // averaging divider shifts (log2 of sample count)
  localparam logic [3:0] SHIFT_16 = 4'h4;
  localparam logic [3:0] SHIFT_32 = 4'h5;
  localparam logic [3:0] SHIFT_64 = 4'h6;
  localparam logic [3:0] SHIFT_256 = 4'h8;
  // lid threshold fraction code to right shift (6.25,12.5,25,50 %)
  localparam logic [2:0] LID_SHIFT_BASE = 3'h4;
endpackage : lcr_pkg

// ===== src/lcr_chan.sv
// per-sensor lid debounce queue and negative delta run counter
`timescale 1ns/100ps
module lcr_chan (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sample_in,
  input wire logic above_in,
  input wire logic [3:0] queue_len_in,
  input wire logic neg_in,
  input wire logic [5:0] neg_limit_in,
  output logic status_out,
  output logic neg_trig_out
);
  logic [2:0] run_q;
  logic [5:0] neg_q;
  logic differ;
  logic flip;
  logic neg_hit;

  // a flip needs queue_len consecutive samples on the other side
  assign differ = above_in != status_out;
  assign flip = differ && ({1'b0, run_q} == queue_len_in - 4'h1);
  // limit of zero means the trigger is disabled
  assign neg_hit = neg_in && (neg_limit_in != lcr_pkg::NEG_RUN_OFF)
                   && (neg_q + 6'h01 == neg_limit_in);

  // debounce: any agreeing sample restarts the run
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      run_q <= 3'h0;
      status_out <= 1'b0;
    end else if (sample_in) begin
      run_q <= (differ && !flip) ? run_q + 3'h1 : 3'h0;
      if (flip) begin
        status_out <= above_in;
      end
    end
  end

  // negative delta run, broken by any non-negative sample
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      neg_q <= 6'h00;
      neg_trig_out <= 1'b0;
    end else begin
      neg_trig_out <= sample_in && neg_hit;
      if (sample_in) begin
        neg_q <= (neg_in && !neg_hit) ? neg_q + 6'h01 : 6'h00;
      end
    end
  end
endmodule : lcr_chan

// ===== sim/lcr_ctrl_props.sv
// assertion checker for the lid and recalibration control block
`timescale 1ns/100ps
module lcr_ctrl_props (
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic SYS_RST_IN,
  // host register port
  input wire logic REG_WR_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  // measurement side
  input wire logic SAMPLE_DONE_IN,
  input wire logic [13:0] NEG_DELTA_IN,
  input wire logic [13:0] NOISE_STATUS_IN,
  input wire logic [13:0] RECAL_EN_IN,
  // observed outputs
  input wire logic LID_EVENT_OUT,
  input wire logic ALERT_OUT,
  input wire logic [13:0] LID_STATUS_OUT,
  input wire logic [13:0] NOISE_LID_OUT,
  input wire logic [13:0] NOISE_TOUCH_OUT,
  input wire logic [7:0] THR_LOAD_OUT,
  input wire logic [6:0] THR_DATA_OUT,
  input wire logic [13:0] NEG_RECAL_OUT,
  input wire logic [3:0] AVG_SHIFT_OUT,
  input wire logic [13:0] BASE_UPDATE_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // threshold loads: a direct write loads only its own register
  a_direct_load: assert property (
    REG_WR_IN && REG_ADDR_IN > 8'h30 && REG_ADDR_IN <= 8'h37 |=>
    THR_LOAD_OUT == (8'h01 << ($past(REG_ADDR_IN) - 8'h30)) &&
    THR_DATA_OUT == $past(REG_WDATA_IN[6:0]))
    else $error("direct threshold load wrong");
  a_first_load: assert property (
    REG_WR_IN && REG_ADDR_IN == 8'h30 |=> THR_LOAD_OUT[0] &&
    THR_LOAD_OUT[7:1] inside {7'h00, 7'h3f, 7'h40, 7'h7f})
    else $error("first threshold load pattern wrong");
  a_idle_no_load: assert property (
    !REG_WR_IN |=> THR_LOAD_OUT == 8'h00)
    else $error("threshold load without a write");
  // lid event, alert and debounce timing, and noise steering
  a_alert_event: assert property (
    ALERT_OUT |-> LID_EVENT_OUT ##1 !ALERT_OUT)
    else $error("alert without lid event or too long");
  a_event_sample: assert property (
    $rose(LID_EVENT_OUT) |-> $past(SAMPLE_DONE_IN, 2))
    else $error("lid event not tied to a sample");
  a_status_sample: assert property (
    !$past(SYS_RST_IN) && LID_STATUS_OUT != $past(LID_STATUS_OUT) |->
    $past(SAMPLE_DONE_IN))
    else $error("lid status moved without a sample");
  a_noise_steer: assert property (
    !$past(SYS_RST_IN) |->
    (NOISE_LID_OUT | NOISE_TOUCH_OUT) == $past(NOISE_STATUS_IN) &&
    (NOISE_LID_OUT & NOISE_TOUCH_OUT) == 14'h0000)
    else $error("noise status steering wrong");
  // recalibration pulses follow their causes; the averaging shift stays legal
  a_neg_cause: assert property (
    NEG_RECAL_OUT != 14'h0000 |-> $past(SAMPLE_DONE_IN) &&
    (NEG_RECAL_OUT & ~$past(NEG_DELTA_IN)) == 14'h0000)
    else $error("negative recal without negative sample");
  a_base_cause: assert property (
    BASE_UPDATE_OUT != 14'h0000 |-> $past(SAMPLE_DONE_IN) &&
    BASE_UPDATE_OUT == $past(RECAL_EN_IN))
    else $error("base update cause wrong");
  a_shift_legal: assert property (
    AVG_SHIFT_OUT inside {4'h4, 4'h5, 4'h6, 4'h8})
    else $error("averaging shift out of range");
endmodule : lcr_ctrl_props

bind lcr_ctrl lcr_ctrl_props chk_u (.*);

// ===== sim/lcr_host.sv
// host-side register master model driving the block's register port
`timescale 1ns/100ps
module lcr_host (
  // clock and read data
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  // register requests
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  // idle bus at time zero
  initial begin
    wr_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // strobe lasts one cycle; data flipped after so nothing stale looks valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask : write_reg
  // read data is registered, so it is taken one edge after the address
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask : read_reg
endmodule : lcr_host

// ===== sim/tb.sv
// self-checking bench for the lid and recalibration control block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  n_fail++; $display("unexpected %s expected %h seen %h", nm, ex, got); \
  end end
module tb;
  logic SYS_CLK_IN = 1'b0;
  logic SYS_RST_IN, REG_WR_IN, SAMPLE_DONE_IN, LID_EVENT_CLR_IN;
  logic LID_EVENT_OUT, ALERT_OUT, AVG_SAMPLE_OUT;
  logic [7:0] REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT, THR_LOAD_OUT;
  logic [111:0] SENSOR_DELTA_IN;
  logic [13:0] NEG_DELTA_IN, NOISE_STATUS_IN, RECAL_EN_IN, LID_STATUS_OUT;
  logic [13:0] NOISE_LID_OUT, NOISE_TOUCH_OUT, NEG_RECAL_OUT, BASE_UPDATE_OUT;
  logic [55:0] SENSOR_THRESH_IN;
  logic [27:0] LID_TH_CODE_IN;
  logic [6:0] THR_DATA_OUT;
  logic [3:0] AVG_SHIFT_OUT;
  logic [7:0] rd;
  logic seen_alert;
  int n_fail = 0, n_compared = 0, cycles = 0, negs = 0, bases = 0, avgs = 0;
  int first_neg;

  lcr_ctrl dut_u (.*);
  lcr_host host_u (.clk_in(SYS_CLK_IN), .rdata_in(REG_RDATA_OUT),
    .wr_out(REG_WR_IN), .addr_out(REG_ADDR_IN), .wdata_out(REG_WDATA_IN));

  // clock, hang guard and alert watcher
  always #5 SYS_CLK_IN = ~SYS_CLK_IN;
  always @(posedge SYS_CLK_IN) begin
    cycles++;
    if (ALERT_OUT === 1'b1) seen_alert <= 1'b1;
    if (cycles == 10000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic do_reset();
    @(posedge SYS_CLK_IN);
    SYS_RST_IN <= 1'b1;
    repeat (3) @(posedge SYS_CLK_IN);
    SYS_RST_IN <= 1'b0;
  endtask : do_reset

  // one sampling cycle at the tightest legal spacing of two clocks
  task automatic sample();
    @(posedge SYS_CLK_IN);
    SAMPLE_DONE_IN <= 1'b1;
    #1;
    avgs += (AVG_SAMPLE_OUT === 1'b1);
    @(posedge SYS_CLK_IN);
    SAMPLE_DONE_IN <= 1'b0;
    #1;
    avgs += (AVG_SAMPLE_OUT === 1'b1);
    negs += (NEG_RECAL_OUT[0] === 1'b1);
    bases += (BASE_UPDATE_OUT !== 14'h0000);
    if (BASE_UPDATE_OUT !== 14'h0000)
      `CHK("base update", 14'h2a5a, BASE_UPDATE_OUT)
  endtask : sample

  task automatic t_regs();
    logic [7:0] rv[5] = '{8'h00, 8'h02, 8'h7f, 8'h7f, 8'h93};
    logic [7:0] wm[5] = '{8'h83, 8'h07, 8'h7f, 8'h7f, 8'hdf};
    logic [3:0] sh[8] = '{4'h4, 4'h5, 4'h6, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8};
    `CHK("reset shift", 4'h8, AVG_SHIFT_OUT)
    for (int i = 0; i < 5; i++) begin
      host_u.read_reg(8'h2b + i[7:0], rd);
      `CHK("reset value", rv[i], rd)
      host_u.write_reg(8'h2b + i[7:0], 8'hff);
      host_u.read_reg(8'h2b + i[7:0], rd);
      `CHK("written value", wm[i], rd)
    end
    host_u.read_reg(8'h40, rd);
    `CHK("unmapped read", 8'h00, rd)
    for (int c = 0; c < 8; c++) begin
      host_u.write_reg(8'h2f, 8'h90 | c[7:0]);
      repeat (2) @(posedge SYS_CLK_IN);
      #1;
      `CHK("averaging shift", sh[c], AVG_SHIFT_OUT)
    end
  endtask : t_regs

  // deltas of 21h sit above the 50% lid threshold of 20h, 20h does not
  task automatic lid_case(input logic [7:0] cfg, m1, m2,
      input logic [13:0] above, input logic ev);
    logic [111:0] dv;
    do_reset();
    host_u.write_reg(8'h2d, m1);
    host_u.write_reg(8'h2e, m2);
    host_u.write_reg(8'h2b, cfg);
    for (int i = 0; i < 14; i++) dv[8*i +: 8] = above[i] ? 8'h21 : 8'h20;
    SENSOR_DELTA_IN <= dv;
    seen_alert = 1'b0;
    repeat (3) sample();
    repeat (6) @(posedge SYS_CLK_IN);
    #1;
    if (cfg[7]) `CHK("lid status", above, LID_STATUS_OUT)
    `CHK("lid event", ev, LID_EVENT_OUT)
    `CHK("alert", ev & cfg[0], seen_alert)
    `CHK("noise", cfg[7] ? 14'h1234 : 14'h0000, NOISE_LID_OUT)
    `CHK("noise touch", cfg[7] ? 14'h0000 : 14'h1234, NOISE_TOUCH_OUT)
    if (ev) begin
      @(posedge SYS_CLK_IN);
      LID_EVENT_CLR_IN <= 1'b1;
      @(posedge SYS_CLK_IN);
      LID_EVENT_CLR_IN <= 1'b0;
      #1;
      `CHK("cleared event", 1'b0, LID_EVENT_OUT)
    end
  endtask : lid_case

  task automatic t_queue();
    do_reset();
    host_u.write_reg(8'h2c, 8'h00);
    SENSOR_DELTA_IN <= {{13{8'h00}}, 8'h21};
    sample();
    `CHK("queue of one", 1'b1, LID_STATUS_OUT[0])
    host_u.write_reg(8'h2c, 8'h07);
    for (int p = 0; p < 2; p++) begin
      SENSOR_DELTA_IN <= {{13{8'h00}}, (p == 0) ? 8'h20 : 8'h21};
      for (int k = 1; k <= 8; k++) begin
        sample();
        `CHK("queued status", (k == 8) ? p[0] : ~p[0], LID_STATUS_OUT[0])
      end
    end
  endtask : t_queue

  task automatic t_neg();
    int lens[4] = '{8, 16, 32, 0};
    for (int c = 0; c < 4; c++) begin
      host_u.write_reg(8'h2f, 8'h80 | (c[7:0] << 3));
      NEG_DELTA_IN <= 14'h0000;
      sample();
      NEG_DELTA_IN <= 14'h0001;
      negs = 0;
      first_neg = 0;
      for (int k = 1; k <= 40; k++) begin
        sample();
        if (negs == 1 && first_neg == 0) first_neg = k;
      end
      `CHK("negative run", lens[c], first_neg)
    end
    NEG_DELTA_IN <= 14'h0000;
  endtask : t_neg

  // short and long interval settings; the long one costs 1024 samples
  task automatic t_recal();
    do_reset();
    host_u.write_reg(8'h2f, 8'h90);
    bases = 0;
    avgs = 0;
    repeat (32) sample();
    `CHK("updates short", 2, bases)
    `CHK("averaged short", 32, avgs)
    host_u.write_reg(8'h2f, 8'h94);
    bases = 0;
    avgs = 0;
    repeat (1024) sample();
    `CHK("updates long", 1, bases)
    `CHK("averaged long", 256, avgs)
  endtask : t_recal

  task automatic t_bcast();
    logic [7:0] cf[3] = '{8'h93, 8'hc3, 8'h13};
    logic [7:0] ld[3] = '{8'h7f, 8'hff, 8'h01};
    do_reset();
    for (int i = 0; i < 3; i++) begin
      host_u.write_reg(8'h2f, cf[i]);
      host_u.write_reg(8'h30, 8'h55);
      #1;
      `CHK("broadcast loads", ld[i], THR_LOAD_OUT)
      `CHK("broadcast data", 7'h55, THR_DATA_OUT)
    end
    host_u.write_reg(8'h37, 8'h2a);
    #1;
    `CHK("group load", 8'h80, THR_LOAD_OUT)
  endtask : t_bcast

  // main sequence
  initial begin
    SYS_RST_IN = 1'b1;
    SAMPLE_DONE_IN = 1'b0;
    LID_EVENT_CLR_IN = 1'b0;
    SENSOR_DELTA_IN = '0;
    NEG_DELTA_IN = 14'h0000;
    NOISE_STATUS_IN = 14'h1234;
    RECAL_EN_IN = 14'h2a5a;
    SENSOR_THRESH_IN = {8{7'h40}};
    LID_TH_CODE_IN = {14{2'b11}};
    seen_alert = 1'b0;
    do_reset();
    t_regs();
    lid_case(8'h00, 8'h7f, 8'h7f, 14'h3fff, 1'b0);
    lid_case(8'h83, 8'h05, 8'h00, 14'h0005, 1'b1);
    lid_case(8'h82, 8'h05, 8'h00, 14'h0004, 1'b0);
    lid_case(8'h80, 8'h03, 8'h7f, 14'h000c, 1'b1);
    lid_case(8'h81, 8'h03, 8'h7f, 14'h0004, 1'b0);
    lid_case(8'h80, 8'h7f, 8'h03, 14'h3000, 1'b1);
    lid_case(8'h81, 8'h00, 8'h00, 14'h3fff, 1'b0);
    t_queue();
    t_neg();
    t_recal();
    t_bcast();
    conclude();
  end
endmodule : tb
